// >>> lcd_clk_gen.sv
// LCD clock generator: produces a one-cycle sub clock tick from the core clock
// and an LCD clock tick every eighth sub clock tick.
// Assumes the core clock is free running; the sub clock is modelled by division.
`timescale 1ns/1ps
module lcd_clk_gen
   import lcd_pkg::*;
#(
   parameter int SUB_DIV = SUB_DIV_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   output logic sub_tick_out,
   output logic lcd_tick_out
);

   typedef struct packed {
      logic [15:0] sub_cnt;
      logic [2:0] lcd_cnt;
      logic sub_tick;
      logic lcd_tick;
   } state_t;

   state_t s_q;
   state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.sub_tick = 1'b0;
      s_d.lcd_tick = 1'b0;
      if (s_q.sub_cnt == 16'(SUB_DIV - 1)) begin
         s_d.sub_cnt = 16'h0000;
         s_d.sub_tick = 1'b1;
         s_d.lcd_cnt = s_q.lcd_cnt + 3'h1;
         if (s_q.lcd_cnt == 3'(LCD_CLK_DIV - 1)) begin
            s_d.lcd_tick = 1'b1;
         end
      end else begin
         s_d.sub_cnt = s_q.sub_cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sub_tick_out = s_q.sub_tick;
   assign lcd_tick_out = s_q.lcd_tick;

endmodule // lcd_clk_gen

// >>> lcd_driver.sv
// Segment LCD driver: control registers, 16-byte display memory in sector 4,
// common phase sequencer, quick charge timing and bias network controls.
// Assumes the core data bus presents one-cycle read and write strobes and that
// the power manager reports sleep and a full device reset on separate inputs.
`timescale 1ns/1ps

//Contract
// - Display memory is sixteen bytes at 00H..0FH of sector 4.
// - A set memory bit lights its pixel, a clear bit darkens it.
// - Memory bits 4 to 7 read as zero and store nothing.
// - LCD clock is the sub clock divided by eight.
// - Master enable acts outside sleep; sleep keeps the display off.
// - Primary bit 7 picks waveform type A or B.
// - Primary bit 6 picks resistor ladder or charge pump bias.
// - Primary bits 5..4 choose the capacitor bias supply.
// - Primary bits 3..1 choose total bias resistor or quick charge.
// - Quick charge uses 60k at each phase start, then high resistor.
// - Secondary bits 7..5 give quick charge length of n+1 sub periods.
// - Secondary bit 4 is unimplemented and reads zero.
// - Secondary bits 3..0 choose the resistor bias top level.
// - Disabled resistor bias opens the ladder current path.
// - Display memory is fetched continuously with no extra command.
// - Disabled or asleep drives pins low; device reset floats them.
module lcd_driver
   import lcd_pkg::*;
#(
   parameter int SUB_DIV = SUB_DIV_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic sleep_in,
   input wire mem_req_t mem_req_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   output bias_ctrl_t bias_ctrl_out,
   output level_t com_level_out [NUM_COM],
   output logic [NUM_COM-1:0] com_oe_out,
   output level_t seg_level_out [NUM_SEG],
   output logic [NUM_SEG-1:0] seg_oe_out
);

   typedef struct packed {
      primary_t primary;
      secondary_t secondary;
      logic [DISP_BYTES-1:0][3:0] disp;
      logic [1:0] phase;
      logic frame_odd;
      logic [3:0] qc_cnt;
      logic qc_active;
      logic [7:0] rdata;
      logic rvalid;
      bias_ctrl_t bias;
      logic [NUM_COM-1:0][1:0] com_lvl;
      logic [NUM_SEG-1:0][1:0] seg_lvl;
      logic pins_driven;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic sub_tick;
   logic lcd_tick;
   logic running;
   logic invert;
   logic [NUM_SEG-1:0] pixels;
   level_t map_com [NUM_COM];
   level_t map_seg [NUM_SEG];

   // True when an access targets one of the sixteen display bytes.
   function automatic logic is_disp(input mem_req_t r);
      is_disp = (r.reg_sel == 2'h0) && (r.sector == DISP_SECTOR) && (r.addr >= DISP_FIRST)
         && (r.addr <= DISP_LAST);
   endfunction

   lcd_clk_gen #(
      .SUB_DIV(SUB_DIV)
   ) u_clk (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .sub_tick_out(sub_tick),
      .lcd_tick_out(lcd_tick)
   );

   assign running = s_q.primary.display_master_enable && !sleep_in;

   // A common is always selected at the same phase parity, so type A must also flip per frame;
   // without that every selected pixel would carry a steady DC offset.
   // type A flips every phase and frame, type B every frame
   assign invert = s_q.primary.wave_type_b ? s_q.frame_odd : (s_q.phase[0] ^ s_q.frame_odd);

   // segment bit for the active common
   always_comb begin
      for (int s = 0; s < NUM_SEG; s++) begin
         pixels[s] = s_q.disp[s][s_q.phase];
      end
   end

   lcd_level_map u_map (
      .phase_in(s_q.phase),
      .invert_in(invert),
      .pixels_in(pixels),
      .com_level_out(map_com),
      .seg_level_out(map_seg)
   );

   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;

      // Register and display memory writes.
      if (mem_req_in.wr) begin
         if (mem_req_in.reg_sel == SEL_PRIMARY) begin
            s_d.primary = mem_req_in.wdata;
         end else if (mem_req_in.reg_sel == SEL_SECONDARY) begin
            s_d.secondary = {mem_req_in.wdata[7:5], mem_req_in.wdata[3:0]};
         end else if (is_disp(mem_req_in)) begin
            s_d.disp[mem_req_in.addr[3:0]] = mem_req_in.wdata[3:0];
         end
      end

      // Reads answer one cycle later; unmapped addresses read zero.
      if (mem_req_in.rd) begin
         s_d.rvalid = 1'b1;
         if (mem_req_in.reg_sel == SEL_PRIMARY) begin
            s_d.rdata = s_q.primary;
         end else if (mem_req_in.reg_sel == SEL_SECONDARY) begin
            s_d.rdata = {s_q.secondary[6:4], 1'b0, s_q.secondary[3:0]} & SECONDARY_RD_MASK;
         end else if (is_disp(mem_req_in)) begin
            s_d.rdata = {4'h0, s_q.disp[mem_req_in.addr[3:0]]} & DISP_RD_MASK;
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // Phase sequencer and quick charge timer.
      if (!running) begin
         s_d.phase = 2'h0;
         s_d.frame_odd = 1'b0;
         s_d.qc_active = 1'b0;
         s_d.qc_cnt = 4'h0;
      end else if (lcd_tick) begin
         s_d.phase = s_q.phase + 2'h1;
         if (s_q.phase == 2'(NUM_COM - 1)) begin
            s_d.frame_odd = !s_q.frame_odd;
         end
         s_d.qc_active = 1'b1;
         s_d.qc_cnt = {1'b0, s_q.secondary.fast_charge_length} + 4'h1;
      end else if (sub_tick && s_q.qc_active) begin
         s_d.qc_cnt = s_q.qc_cnt - 4'h1;
         if (s_q.qc_cnt == 4'h1) begin
            s_d.qc_active = 1'b0;
         end
      end

      // Bias network controls.
      s_d.bias = '0;
      s_d.bias.top_level = s_q.secondary.top_level_ratio;
      s_d.bias.pump_source = s_q.primary.pump_source_select;
      if (running) begin
         if (s_q.primary.bias_network_select) begin
            s_d.bias.pump_on = 1'b1;
         end else begin
            s_d.bias.ladder_on = 1'b1;
            unique casez (s_q.primary.bias_resistor_select)
               RES_1170K: s_d.bias.res_1170k = 1'b1;
               RES_225K: s_d.bias.res_225k = 1'b1;
               RES_60K: s_d.bias.res_60k = 1'b1;
               RES_QC_1170K: begin
                  s_d.bias.res_60k = s_q.qc_active;
                  s_d.bias.res_1170k = !s_q.qc_active;
               end
               3'b1??: begin
                  s_d.bias.res_60k = s_q.qc_active;
                  s_d.bias.res_225k = !s_q.qc_active;
               end
            endcase
         end
      end

      s_d.pins_driven = 1'b1;
      for (int c = 0; c < NUM_COM; c++) begin
         s_d.com_lvl[c] = running ? map_com[c] : 2'h0;
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         s_d.seg_lvl[s] = running ? map_seg[s] : 2'h0;
      end
   end

   // Display memory is not cleared by reset; its power-up content is undefined.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s_q.primary <= PRIMARY_RESET;
         s_q.secondary <= secondary_t'({SECONDARY_RESET[7:5], SECONDARY_RESET[3:0]});
         s_q.phase <= 2'h0;
         s_q.frame_odd <= 1'b0;
         s_q.qc_cnt <= 4'h0;
         s_q.qc_active <= 1'b0;
         s_q.rdata <= 8'h00;
         s_q.rvalid <= 1'b0;
         s_q.bias <= '0;
         s_q.com_lvl <= '0;
         s_q.seg_lvl <= '0;
         s_q.pins_driven <= 1'b0;
      end else begin
         s_q.primary <= s_d.primary;
         s_q.secondary <= s_d.secondary;
         s_q.phase <= s_d.phase;
         s_q.frame_odd <= s_d.frame_odd;
         s_q.qc_cnt <= s_d.qc_cnt;
         s_q.qc_active <= s_d.qc_active;
         s_q.rdata <= s_d.rdata;
         s_q.rvalid <= s_d.rvalid;
         s_q.bias <= s_d.bias;
         s_q.com_lvl <= s_d.com_lvl;
         s_q.seg_lvl <= s_d.seg_lvl;
         s_q.pins_driven <= s_d.pins_driven;
      end
      s_q.disp <= s_d.disp;
   end

   assign rdata_out = s_q.rdata;
   assign rvalid_out = s_q.rvalid;
   assign bias_ctrl_out = s_q.bias;
   assign com_oe_out = {NUM_COM{s_q.pins_driven}};
   assign seg_oe_out = {NUM_SEG{s_q.pins_driven}};

   always_comb begin
      for (int c = 0; c < NUM_COM; c++) begin
         com_level_out[c] = s_q.com_lvl[c];
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         seg_level_out[s] = s_q.seg_lvl[s];
      end
   end

endmodule // lcd_driver

// >>> lcd_driver_sva.sv
// Port checker for the segment LCD driver.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module lcd_driver_chk
   import lcd_pkg::*;
#(
   parameter int SUB_DIV = SUB_DIV_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic sleep_in,
   input wire mem_req_t mem_req_in,
   input wire logic [7:0] rdata_out,
   input wire logic rvalid_out,
   input wire bias_ctrl_t bias_ctrl_out,
   input wire level_t com_level_out [NUM_COM],
   input wire logic [NUM_COM-1:0] com_oe_out,
   input wire level_t seg_level_out [NUM_SEG],
   input wire logic [NUM_SEG-1:0] seg_oe_out
);
   primary_t prim_q;
   secondary_t sec_q;
   logic lvl_any;
   int hi_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   always_comb begin
      lvl_any = 1'b0;
      for (int i = 0; i < NUM_COM; i++) lvl_any |= |com_level_out[i];
      for (int i = 0; i < NUM_SEG; i++) lvl_any |= |seg_level_out[i];
   end
   // Shadow of the primary register, so enable and mode are known at the ports.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         prim_q <= PRIMARY_RESET;
         sec_q <= secondary_t'({SECONDARY_RESET[7:5], SECONDARY_RESET[3:0]});
         hi_q <= 0;
      end else begin
         if (mem_req_in.wr && mem_req_in.reg_sel == SEL_PRIMARY) prim_q <= mem_req_in.wdata;
         if (mem_req_in.wr && mem_req_in.reg_sel == SEL_SECONDARY) begin
            sec_q <= {mem_req_in.wdata[7:5], mem_req_in.wdata[3:0]};
         end
         hi_q <= bias_ctrl_out.res_60k ? hi_q + 1 : 0;
      end
   end
   float_in_reset_a: assert property (disable iff (1'b0)
      sys_rst_in |=> !(|com_oe_out) && !(|seg_oe_out)) else $error("pins driven in reset");
   drive_after_reset_a: assert property (!sys_rst_in ##1 !sys_rst_in |->
      (&com_oe_out) && (&seg_oe_out)) else $error("pins float outside reset");
   sleep_low_a: assert property (sleep_in [*3] |-> !lvl_any) else $error("levels in sleep");
   off_low_a: assert property (!prim_q.display_master_enable [*3] |->
      !lvl_any && !bias_ctrl_out.ladder_on) else $error("disabled driver active");
   read_pulse_a: assert property (rvalid_out == $past(mem_req_in.rd)) else $error("read pulse");
   mem_high_zero_a: assert property (mem_req_in.rd && mem_req_in.reg_sel == 2'h0 |=>
      rdata_out[7:4] == 4'h0) else $error("display bits 7:4 set");
   sec_bit_zero_a: assert property (mem_req_in.rd && mem_req_in.reg_sel == SEL_SECONDARY |=>
      !rdata_out[4]) else $error("secondary bit 4 set");
   unmapped_zero_a: assert property (mem_req_in.rd && mem_req_in.reg_sel == 2'h3 |=>
      rdata_out == 8'h00) else $error("unmapped read not zero");
   // The longest length fills a whole phase, so the low resistor then legally never drops.
   quick_len_a: assert property (sec_q.fast_charge_length != 3'h7 |->
      hi_q <= (int'(sec_q.fast_charge_length) + 1) * SUB_DIV) else $error("quick charge too long");
   pump_on_a: assert property ((prim_q.bias_network_select && prim_q.display_master_enable
      && !sleep_in) [*3] |-> bias_ctrl_out.pump_on) else $error("pump off");
   cover property (bias_ctrl_out.res_60k ##1 !bias_ctrl_out.res_60k);
   cover property (sleep_in [*3] ##1 !sleep_in);
   cover property (rvalid_out && rdata_out[3:0] != 4'h0);
endmodule // lcd_driver_chk

bind lcd_driver lcd_driver_chk #(.SUB_DIV(SUB_DIV)) lcd_driver_chk_i (.core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in), .sleep_in(sleep_in), .mem_req_in(mem_req_in), .rdata_out(rdata_out),
   .rvalid_out(rvalid_out), .bias_ctrl_out(bias_ctrl_out), .com_level_out(com_level_out),
   .com_oe_out(com_oe_out), .seg_level_out(seg_level_out), .seg_oe_out(seg_oe_out));

// >>> lcd_glass_model.sv
// Glass model: a pixel lights when its common is selected and sees a full swing.
// Assumes 1/3 bias level codes from the driver, sampled on the core clock.
`timescale 1ns/1ps
module lcd_glass_model
   import lcd_pkg::*;
(
   input wire logic core_clk_in,
   input wire level_t com_in [NUM_COM],
   input wire level_t seg_in [NUM_SEG],
   output logic [NUM_COM*NUM_SEG-1:0] lit_out
);
   initial lit_out = '0;
   always @(posedge core_clk_in) begin
      for (int c = 0; c < NUM_COM; c++) begin
         for (int s = 0; s < NUM_SEG; s++) begin
            if (com_in[c] inside {2'h0, 2'h3}) lit_out[c*NUM_SEG+s] <= (com_in[c] ^ seg_in[s]) == 2'h3;
         end
      end
   end
endmodule // lcd_glass_model

// >>> lcd_level_map.sv
// Level mapper: turns phase, frame polarity and pixel data into 1/3 bias drive
// levels for all commons and all segments.
// Assumes the caller registers the results; this module is purely combinational.
`timescale 1ns/1ps
module lcd_level_map
   import lcd_pkg::*;
(
   input wire logic [1:0] phase_in,
   input wire logic invert_in,
   input wire logic [NUM_SEG-1:0] pixels_in,
   output level_t com_level_out [NUM_COM],
   output level_t seg_level_out [NUM_SEG]
);

   // Selected common is at the far rail, others at the near third.
   function automatic level_t com_lvl(input logic sel, input logic inv);
      if (sel) begin
         com_lvl = inv ? 2'h0 : 2'h3;
      end else begin
         com_lvl = inv ? 2'h2 : 2'h1;
      end
   endfunction

   always_comb begin
      for (int c = 0; c < NUM_COM; c++) begin
         com_level_out[c] = com_lvl(phase_in == 2'(c), invert_in);
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         if (pixels_in[s]) begin
            seg_level_out[s] = invert_in ? 2'h3 : 2'h0;
         end else begin
            seg_level_out[s] = invert_in ? 2'h1 : 2'h2;
         end
      end
   end

endmodule // lcd_level_map

// >>> lcd_pkg.sv
// Package for the segment LCD driver: control register layout, reset values,
// panel geometry and timing constants shared by the driver and its helpers.
// Assumes a single core clock domain at 10 MHz and an 8-bit data memory bus.
package lcd_pkg;

   localparam int NUM_SEG = 12;
   localparam int NUM_COM = 4;
   localparam int DISP_BYTES = 16;

   // Display memory window inside data memory sector 4.
   localparam logic [7:0] DISP_SECTOR = 8'h04;
   localparam logic [7:0] DISP_FIRST = 8'h00;
   localparam logic [7:0] DISP_LAST = 8'h0f;

   // Register select codes on the core data bus.
   localparam logic [1:0] SEL_PRIMARY = 2'h1;
   localparam logic [1:0] SEL_SECONDARY = 2'h2;

   localparam logic [7:0] PRIMARY_RESET = 8'h00;
   localparam logic [7:0] SECONDARY_RESET = 8'h00;
   localparam logic [7:0] SECONDARY_RD_MASK = 8'hef;
   localparam logic [7:0] DISP_RD_MASK = 8'h0f;

   // Primary control field positions.
   localparam int WAVE_TYPE_BIT = 7;
   localparam int BIAS_NET_BIT = 6;
   localparam int PUMP_SRC_LSB = 4;
   localparam int BIAS_RES_LSB = 1;
   localparam int MASTER_EN_BIT = 0;
   // Secondary control field positions.
   localparam int FAST_LEN_LSB = 5;
   localparam int TOP_LEVEL_LSB = 0;

   // Bias resistor codes.
   localparam logic [2:0] RES_1170K = 3'h0;
   localparam logic [2:0] RES_225K = 3'h1;
   localparam logic [2:0] RES_60K = 3'h2;
   localparam logic [2:0] RES_QC_1170K = 3'h3;

   // Sub clock timing: the core clock is 10 MHz, the sub clock 32 kHz.
   localparam int CORE_CLK_HZ = 10_000_000;
   localparam int SUB_CLK_HZ = 32_000;
   localparam int SUB_DIV_CYCLES = CORE_CLK_HZ / SUB_CLK_HZ;
   localparam int LCD_CLK_DIV = 8;

   typedef struct packed {
      logic wave_type_b;
      logic bias_network_select;
      logic [1:0] pump_source_select;
      logic [2:0] bias_resistor_select;
      logic display_master_enable;
   } primary_t;

   typedef struct packed {
      logic [2:0] fast_charge_length;
      logic [3:0] top_level_ratio;
   } secondary_t;

   // Core data memory access strobes.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] sector;
      logic [7:0] addr;
      logic [1:0] reg_sel;
      logic [7:0] wdata;
   } mem_req_t;

   // Bias network controls toward the analog block.
   typedef struct packed {
      logic ladder_on;
      logic pump_on;
      logic [1:0] pump_source;
      logic res_60k;
      logic res_225k;
      logic res_1170k;
      logic [3:0] top_level;
   } bias_ctrl_t;

   // Drive level codes for a 1/3 bias pin: 0 = ground, 3 = top level.
   typedef logic [1:0] level_t;

endpackage

// >>> tb_top.sv
// Testbench for the LCD driver with a glass model on its pins.
// Assumes a 10 MHz core clock and a shortened sub clock divider.
`timescale 1ns/1ps
module tb_top
   import lcd_pkg::*;
;
   localparam int SD = 4;
   localparam int FRAME = 32 * SD;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic sleep_in = 1'b0;
   mem_req_t req = '0;
   logic [7:0] rdata;
   logic rvalid;
   bias_ctrl_t bias;
   level_t com_lvl [NUM_COM];
   level_t seg_lvl [NUM_SEG];
   logic [NUM_COM-1:0] com_oe;
   logic [NUM_SEG-1:0] seg_oe;
   logic [47:0] lit;
   logic [7:0] pat [NUM_SEG];
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 core_clk_in = ~core_clk_in;
   lcd_driver #(.SUB_DIV(SD)) lcd_driver_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .sleep_in(sleep_in), .mem_req_in(req), .rdata_out(rdata), .rvalid_out(rvalid), .bias_ctrl_out(bias),
      .com_level_out(com_lvl), .com_oe_out(com_oe), .seg_level_out(seg_lvl), .seg_oe_out(seg_oe));
   lcd_glass_model lcd_glass_model_i (.core_clk_in(core_clk_in), .com_in(com_lvl), .seg_in(seg_lvl),
      .lit_out(lit));
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] sel, input logic [7:0] sec, input logic [7:0] adr, input logic [7:0] dat);
      @(negedge core_clk_in);
      req = '{wr: 1'b1, rd: 1'b0, sector: sec, addr: adr, reg_sel: sel, wdata: dat};
      @(negedge core_clk_in);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [1:0] sel, input logic [7:0] sec, input logic [7:0] adr, input logic [7:0] exp);
      @(negedge core_clk_in);
      req = '{wr: 1'b0, rd: 1'b1, sector: sec, addr: adr, reg_sel: sel, wdata: 8'h00};
      @(negedge core_clk_in);
      req.rd = 1'b0;
      check({rvalid, rdata}, {1'b1, exp}, "read");
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task automatic t_regs;
      rd(SEL_PRIMARY, 8'h00, 8'h00, PRIMARY_RESET);
      rd(SEL_SECONDARY, 8'h00, 8'h00, SECONDARY_RESET);
      wr(SEL_SECONDARY, 8'h00, 8'h00, 8'hff);
      rd(SEL_SECONDARY, 8'h00, 8'h00, 8'hef);
      wait_cycles(2);
      check(bias.top_level, 4'hf, "top level");
      wr(SEL_PRIMARY, 8'h00, 8'h00, 8'hfe);
      rd(SEL_PRIMARY, 8'h00, 8'h00, 8'hfe);
      rd(2'h3, 8'h00, 8'h00, 8'h00);
   endtask
   task automatic t_mem;
      for (int k = 0; k < DISP_BYTES; k++) wr(2'h0, DISP_SECTOR, 8'(k), 8'hf0 | 8'(k));
      for (int k = 0; k < DISP_BYTES; k++) rd(2'h0, DISP_SECTOR, 8'(k), 8'(k));
      wr(2'h0, DISP_SECTOR, 8'h10, 8'hff);
      rd(2'h0, DISP_SECTOR, 8'h10, 8'h00);
      rd(2'h0, DISP_SECTOR, 8'h00, 8'h00);
      wr(2'h0, 8'h03, 8'h01, 8'hff);
      rd(2'h0, DISP_SECTOR, 8'h01, 8'h01);
      rd(2'h0, 8'h03, 8'h00, 8'h00);
   endtask
   task automatic t_show(input logic type_b);
      logic [47:0] exp;
      int dc [NUM_COM*NUM_SEG];
      exp = '0;
      dc = '{default: 0};
      for (int k = 0; k < NUM_SEG; k++) begin
         wr(2'h0, DISP_SECTOR, 8'(k), pat[k]);
         for (int c = 0; c < NUM_COM; c++) exp[c*NUM_SEG+k] = pat[k][c];
      end
      wr(SEL_PRIMARY, 8'h00, 8'h00, {type_b, 7'h01});
      wait_cycles(2 * FRAME);
      check(lit, exp, "pixels");
      // The waveform repeats every two frames, so any two-frame window must sum to zero.
      for (int i = 0; i < 2 * FRAME; i++) begin
         @(negedge core_clk_in);
         for (int c = 0; c < NUM_COM; c++) begin
            for (int k = 0; k < NUM_SEG; k++) dc[c*NUM_SEG+k] += int'(com_lvl[c]) - int'(seg_lvl[k]);
         end
      end
      for (int i = 0; i < NUM_COM * NUM_SEG; i++) check(dc[i], 0, "pixel dc");
   endtask
   task automatic t_off;
      @(negedge core_clk_in);
      sleep_in = 1'b1;
      wait_cycles(4);
      check(lit, 48'h0, "sleep pixels");
      check({com_oe, seg_oe}, 16'hffff, "enables");
      sleep_in = 1'b0;
      wr(SEL_PRIMARY, 8'h00, 8'h00, 8'h80);
      wait_cycles(4);
      check({lit, bias.ladder_on}, 49'h0, "disabled");
   endtask
   task automatic t_quick(input logic [2:0] n, input logic [7:0] prim, input logic [1:0] high_res);
      int w;
      int hi;
      w = 0;
      hi = 0;
      wr(SEL_SECONDARY, 8'h00, 8'h00, {n, 5'h08});
      wr(SEL_PRIMARY, 8'h00, 8'h00, prim);
      while (!bias.res_60k && w < 2 * FRAME) begin
         @(negedge core_clk_in);
         w++;
      end
      while (bias.res_60k && hi < 2 * FRAME) begin
         @(negedge core_clk_in);
         hi++;
      end
      check(hi, (n + 1) * SD, "quick length");
      check({bias.res_225k, bias.res_1170k}, high_res, "high resistor");
   endtask
   task automatic t_bias;
      for (int p = 0; p < 4; p++) begin
         wr(SEL_PRIMARY, 8'h00, 8'h00, 8'h41 | 8'(p << 4));
         wait_cycles(3);
         check({bias.pump_on, bias.ladder_on, bias.pump_source}, {2'b10, 2'(p)}, "pump");
      end
      for (int r = 0; r < 3; r++) begin
         wr(SEL_PRIMARY, 8'h00, 8'h00, 8'h01 | 8'(r << 1));
         wait_cycles(3);
         check({bias.ladder_on, bias.pump_on, bias.res_60k, bias.res_225k, bias.res_1170k},
            {2'b10, 3'(3'h1 << r)}, "resistor");
      end
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict;
      end
   end
   initial begin
      wait_cycles(4);
      check({com_oe, seg_oe}, 16'h0, "float");
      sys_rst_in = 1'b0;
      t_regs;
      t_mem;
      for (int k = 0; k < NUM_SEG; k++) pat[k] = 8'(k * 3 + 5);
      t_show(1'b0);
      for (int k = 0; k < NUM_SEG; k++) pat[k] = ~pat[k];
      t_show(1'b1);
      t_off;
      t_quick(3'h0, 8'h07, 2'b01);
      t_quick(3'h6, 8'h09, 2'b10);
      t_bias;
      print_verdict;
   end
endmodule // tb_top
